// File: mcuih_regs.vh
// Constants for the microcontroller interrupt handler.
`ifndef MCUIH_REGS_VH
`define MCUIH_REGS_VH
`define MCUIH_NSRC 8
`define MCUIH_SRC_EXT0 0
`define MCUIH_SRC_TMR0 1
`define MCUIH_SRC_EXT1 2
`define MCUIH_SRC_TMR1 3
`define MCUIH_SRC_SER 4
`define MCUIH_SRC_USB 5
`define MCUIH_SRC_VBUS 6
`define MCUIH_GLOBAL_EN_BIT 7
`define MCUIH_VEC_RESET 16'h0000
`define MCUIH_VEC_EXT0 16'h0003
`define MCUIH_VEC_TMR0 16'h000B
`define MCUIH_VEC_EXT1 16'h0013
`define MCUIH_VEC_TMR1 16'h001B
`define MCUIH_VEC_SER 16'h0023
`define MCUIH_VEC_USB 16'h0043
`define MCUIH_VEC_VBUS 16'h007B
`define MCUIH_ENABLE_RESET 8'h00
`define MCUIH_LEVEL_RESET 8'h00
`define MCUIH_DETECT_CYCLES 1
`define MCUIH_CALL_CYCLES 3'h4
`define MCUIH_LF_DIV_CYCLES 2
`endif

// File: mcuih_top.v
// Interrupt handler: pending flags, enables, two-level arbitration and vector call.
`timescale 1ns/1ps
// Overview of operation
// - Seven request sources, each assigned to one of two priority levels.
// - Valid events set pending flags even when the source is disabled.
// - Enabled pending request causes long call after current instruction completes.
// - Per-source enables act only while the global enable is one.
// - Request may be taken during a global-enable clear before a single-cycle instruction; here i_instr_single_cycle is unused and the enable is sampled live.
// - Flag still set after return raises a new request at once.
// - Software setting a pending flag acts like a real event.
// - First external source selects edge or level detection.
// - Polarity select chooses pin, edge direction and active level.
// - Second external source requests every two low-frequency oscillator cycles when selected.
// - Otherwise second external source requests on oscillator resume.
// - Reset leaves both external pending flags set.
// - High preempts low, nothing preempts high, all default low.
// - Higher level first, then fixed source order.
// - Sample every clock; fastest response is five cycles.
// - After a return, one more instruction runs before the next call.
// - Equal or lower requests wait for return and next instruction.
// - Requests during memory write stall wait for the stall end.
// - Each source has a fixed vector address.
// - Hardware clears external and timer flags on vectoring; others stay set.
// - Enable and level bits sit in matching register positions.
`include "mcuih_regs.vh"
module mcuih_top (
  input wire i_ref_clk,
  input wire i_rst_b,
  input wire [7:0] i_irq_enable_reg,
  input wire [7:0] i_irq_level_reg,
  input wire [7:0] i_ext_enable_reg_one,
  input wire [7:0] i_ext_enable_reg_two,
  input wire [7:0] i_ext_level_reg_one,
  input wire [7:0] i_ext_level_reg_two,
  input wire i_ext0_trigger_select,
  input wire i_ext0_polarity_select,
  input wire i_ext1_source_select,
  input wire i_pin_p00,
  input wire i_pin_p02,
  input wire i_lf_osc_tick,
  input wire i_osc_resume,
  input wire i_timer0_overflow,
  input wire i_timer1_overflow,
  input wire i_serial_rx_event,
  input wire i_serial_tx_event,
  input wire i_usb_request,
  input wire i_bus_voltage_request,
  input wire [3:0] i_flag_set_wr,
  input wire [3:0] i_flag_clr_wr,
  input wire [1:0] i_serial_set_wr,
  input wire [1:0] i_serial_clr_wr,
  input wire i_instr_boundary,
  input wire i_instr_single_cycle,
  input wire i_return_from_irq,
  input wire i_stall,
  output reg o_long_call,
  output reg [15:0] o_vector,
  output reg o_call_busy,
  output reg o_ext0_pending,
  output reg o_timer0_overflow_pending,
  output reg o_ext1_pending,
  output reg o_timer1_overflow_pending,
  output reg o_serial_rx_pending,
  output reg o_serial_tx_pending,
  output reg [1:0] o_in_service
);
  localparam ST_IDLE = 2'd0;
  localparam ST_CALL = 2'd1;
  localparam [2:0] CALL_LAST = `MCUIH_CALL_CYCLES - 3'h1;

  reg [1:0] state;
  reg [2:0] call_cnt;
  reg [2:0] call_src;
  reg call_high;
  reg ext0_pin_q;
  reg lf_half;
  reg after_return;
  reg ext0_event;
  reg ext0_sample;
  reg [6:0] pend;
  reg [6:0] en;
  reg [6:0] lvl;
  reg [6:0] req;
  reg [2:0] next_src;
  reg next_high;
  reg next_found;
  reg take;
  reg gate_ok;
  integer k;

  always @* begin
    ext0_sample = i_ext0_polarity_select ? ~i_pin_p02 : i_pin_p00;
    ext0_event = i_ext0_trigger_select ? (ext0_sample & ~ext0_pin_q) : ext0_sample;
  end

  always @* begin
    pend = {i_bus_voltage_request, i_usb_request,
            o_serial_rx_pending | o_serial_tx_pending, o_timer1_overflow_pending,
            o_ext1_pending, o_timer0_overflow_pending, o_ext0_pending};
    en = {i_ext_enable_reg_two[0], i_ext_enable_reg_one[1], i_irq_enable_reg[4:0]};
    lvl = {i_ext_level_reg_two[0], i_ext_level_reg_one[1], i_irq_level_reg[4:0]};
    // The global enable is sampled live, so a clear racing a request may lose.
    req = pend & en & {7{i_irq_enable_reg[`MCUIH_GLOBAL_EN_BIT]}};
  end

  // Lower index wins within a level; the loop runs downward so index 0 ends last.
  always @* begin
    next_src = 3'd0;
    next_high = 1'b0;
    next_found = 1'b0;
    for (k = 6; k >= 0; k = k - 1) begin
      if (req[k] & lvl[k]) begin
        next_src = k[2:0];
        next_high = 1'b1;
        next_found = 1'b1;
      end
    end
    if (!next_found) begin
      for (k = 6; k >= 0; k = k - 1) begin
        if (req[k]) begin
          next_src = k[2:0];
          next_found = 1'b1;
        end
      end
    end
    if (next_high)
      gate_ok = ~o_in_service[1];
    else
      gate_ok = (o_in_service == 2'b00);
    take = next_found & gate_ok & (state == ST_IDLE) & i_instr_boundary & ~i_stall
           & ~after_return;
  end

  function [15:0] vec_of;
    input [2:0] s;
    begin
      case (s)
        3'd0: vec_of = `MCUIH_VEC_EXT0;
        3'd1: vec_of = `MCUIH_VEC_TMR0;
        3'd2: vec_of = `MCUIH_VEC_EXT1;
        3'd3: vec_of = `MCUIH_VEC_TMR1;
        3'd4: vec_of = `MCUIH_VEC_SER;
        3'd5: vec_of = `MCUIH_VEC_USB;
        3'd6: vec_of = `MCUIH_VEC_VBUS;
        default: vec_of = `MCUIH_VEC_RESET;
      endcase
    end
  endfunction

  always @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state <= ST_IDLE;
      call_cnt <= 3'd0;
      call_src <= 3'd0;
      call_high <= 1'b0;
      ext0_pin_q <= 1'b0;
      lf_half <= 1'b0;
      after_return <= 1'b0;
      o_long_call <= 1'b0;
      o_vector <= `MCUIH_VEC_RESET;
      o_call_busy <= 1'b0;
      o_ext0_pending <= 1'b1;
      o_ext1_pending <= 1'b1;
      o_timer0_overflow_pending <= 1'b0;
      o_timer1_overflow_pending <= 1'b0;
      o_serial_rx_pending <= 1'b0;
      o_serial_tx_pending <= 1'b0;
      o_in_service <= 2'b00;
    end else begin
      ext0_pin_q <= ext0_sample;
      o_long_call <= 1'b0;
      if (i_ext1_source_select && i_lf_osc_tick)
        lf_half <= ~lf_half;

      // Clears come first so a same-cycle event or software set wins.
      if (i_flag_clr_wr[0] || (take && next_src == 3'd0))
        o_ext0_pending <= 1'b0;
      if (i_flag_clr_wr[1] || (take && next_src == 3'd1))
        o_timer0_overflow_pending <= 1'b0;
      if (i_flag_clr_wr[2] || (take && next_src == 3'd2))
        o_ext1_pending <= 1'b0;
      if (i_flag_clr_wr[3] || (take && next_src == 3'd3))
        o_timer1_overflow_pending <= 1'b0;
      if (i_serial_clr_wr[0])
        o_serial_rx_pending <= 1'b0;
      if (i_serial_clr_wr[1])
        o_serial_tx_pending <= 1'b0;
      if (ext0_event || i_flag_set_wr[0])
        o_ext0_pending <= 1'b1;
      if (i_timer0_overflow || i_flag_set_wr[1])
        o_timer0_overflow_pending <= 1'b1;
      if ((i_ext1_source_select && i_lf_osc_tick && lf_half)
          || (!i_ext1_source_select && i_osc_resume) || i_flag_set_wr[2])
        o_ext1_pending <= 1'b1;
      if (i_timer1_overflow || i_flag_set_wr[3])
        o_timer1_overflow_pending <= 1'b1;
      if (i_serial_rx_event || i_serial_set_wr[0])
        o_serial_rx_pending <= 1'b1;
      if (i_serial_tx_event || i_serial_set_wr[1])
        o_serial_tx_pending <= 1'b1;

      // One instruction must complete after a return before another call.
      if (i_return_from_irq) begin
        after_return <= 1'b1;
        if (o_in_service[1])
          o_in_service[1] <= 1'b0;
        else
          o_in_service[0] <= 1'b0;
      end else if (after_return && i_instr_boundary && !i_stall) begin
        after_return <= 1'b0;
      end

      case (state)
        ST_IDLE: begin
          if (take) begin
            state <= ST_CALL;
            call_src <= next_src;
            call_high <= next_high;
            call_cnt <= 3'd0;
            o_call_busy <= 1'b1;
          end
        end
        ST_CALL: begin
          if (call_cnt == CALL_LAST) begin
            state <= ST_IDLE;
            o_long_call <= 1'b1;
            o_vector <= vec_of(call_src);
            o_call_busy <= 1'b0;
            if (call_high)
              o_in_service[1] <= 1'b1;
            else
              o_in_service[0] <= 1'b1;
          end else begin
            call_cnt <= call_cnt + 3'd1;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule // mcuih_top

// File: mcuih_properties.sv
// Checker of call timing, gating and vectors of the interrupt handler.
`timescale 1ns/1ps
module mcuih_props (
  input wire i_ref_clk,
  input wire i_rst_b,
  input wire [7:0] i_irq_enable_reg,
  input wire i_instr_boundary,
  input wire i_return_from_irq,
  input wire i_stall,
  input wire o_long_call,
  input wire [15:0] o_vector,
  input wire o_call_busy,
  input wire [1:0] o_in_service
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);
  AST_CALL: assert property ($rose(o_call_busy) |-> ##4 o_long_call)
    else $error("call not four cycles after take");
  AST_BUSY: assert property ($rose(o_call_busy) |-> o_call_busy [*4] ##1 !o_call_busy)
    else $error("busy length wrong");
  AST_PULSE: assert property (o_long_call |=> !o_long_call)
    else $error("call pulse too long");
  AST_GLOB: assert property ($rose(o_call_busy) |-> $past(i_irq_enable_reg[7]))
    else $error("take while globally disabled");
  AST_STALL: assert property ($rose(o_call_busy) |->
    $past(i_instr_boundary) && !$past(i_stall)) else $error("take off boundary");
  AST_HIGH: assert property ($rose(o_call_busy) |-> !$past(o_in_service[1]))
    else $error("high routine preempted");
  AST_RET: assert property ($rose(o_call_busy) |-> !$past(i_return_from_irq))
    else $error("take right at return");
  AST_VEC: assert property (o_long_call |-> o_vector inside
    {16'h0003, 16'h000B, 16'h0013, 16'h001B, 16'h0023, 16'h0043, 16'h007B})
    else $error("bad vector");
endmodule // mcuih_props
bind mcuih_top mcuih_props mcuih_props_inst (.*);

// File: mcuih_cpu_model.sv
// Core stand-in: instruction boundaries of random length and service returns.
`timescale 1ns/1ps
module mcuih_cpu_model (
  input wire i_ref_clk,
  input wire i_long_call,
  output reg o_instr_boundary,
  output reg o_return_from_irq
);
  integer cnt = 0;
  integer svc = 0;
  initial o_instr_boundary = 1'b0;
  initial o_return_from_irq = 1'b0;
  // Lengths up to eight cycles stand in for the slowest instruction.
  always @(posedge i_ref_clk) begin
    o_instr_boundary <= #1 (cnt == 0 && svc != 1);
    o_return_from_irq <= #1 (svc == 1);
    cnt <= (cnt == 0) ? $urandom % 8 : cnt - 1;
    svc <= i_long_call ? 9 : (svc > 0) ? svc - 1 : 0;
  end
endmodule // mcuih_cpu_model

// File: mcuih_top_bench.sv
// Self-checking bench of the interrupt handler with a core stand-in.
`timescale 1ns/1ps
module mcuih_top_bench;
  localparam [111:0] VT = {16'h007B, 16'h0043, 16'h0023, 16'h001B, 16'h0013, 16'h000B, 16'h0003};
  reg i_ref_clk = 0, i_rst_b = 0, i_ext0_polarity_select = 0, i_pin_p00 = 0, i_pin_p02 = 1;
  reg i_ext1_source_select = 0, i_lf_osc_tick = 0, i_osc_resume = 0, i_timer0_overflow = 0;
  reg i_usb_request = 0, i_bus_voltage_request = 0, i_ext0_trigger_select = 1;
  reg [7:0] i_irq_enable_reg = 0, i_irq_level_reg = 0, i_ext_enable_reg_one = 0;
  reg [7:0] i_ext_enable_reg_two = 0, i_ext_level_reg_one = 0, i_ext_level_reg_two = 0;
  reg [3:0] i_flag_set_wr = 0, i_flag_clr_wr = 0, wb;
  reg [1:0] i_serial_set_wr = 0, i_serial_clr_wr = 0;
  reg [6:0] m, lv;
  reg [15:0] x;
  wire i_serial_tx_event = 1'b0, i_instr_single_cycle = 1'b0;
  wire i_stall = 1'b0, i_timer1_overflow = i_timer0_overflow, i_serial_rx_event = i_timer0_overflow;
  wire i_instr_boundary, i_return_from_irq, o_long_call, o_call_busy, o_ext0_pending, o_ext1_pending;
  wire o_timer0_overflow_pending, o_timer1_overflow_pending, o_serial_rx_pending, o_serial_tx_pending;
  wire [15:0] o_vector;
  wire [1:0] o_in_service;
  integer n_fail = 0, checks_done = 0, i, k, w;
  mcuih_cpu_model mcuih_cpu_model_inst (.i_ref_clk(i_ref_clk), .i_long_call(o_long_call),
    .o_instr_boundary(i_instr_boundary), .o_return_from_irq(i_return_from_irq));
  mcuih_top mcuih_top_inst (.*);
  // Higher level wins, then the lower source index.
  function [15:0] win(input [6:0] mm, input [6:0] hi);
    integer j;
    begin
      win = 16'hFFFF;
      for (j = 6; j >= 0; j = j - 1) if (mm[j] & ~hi[j]) win = VT[j*16 +: 16];
      for (j = 6; j >= 0; j = j - 1) if (mm[j] & hi[j]) win = VT[j*16 +: 16];
    end
  endfunction
  task chk(input string nm, input [15:0] seen, input [15:0] exp);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp) begin
        n_fail = n_fail + 1;
        $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task tick(input integer n);
    begin
      repeat (n) @(posedge i_ref_clk);
      #1;
    end
  endtask
  task clr;
    begin
      i_flag_clr_wr = 4'hF;
      i_serial_clr_wr = 2'h3;
      tick(1);
      i_flag_clr_wr = 4'h0;
      i_serial_clr_wr = 2'h0;
      tick(1);
    end
  endtask
  task conclude;
    begin
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  initial forever #2 i_ref_clk = ~i_ref_clk;
  initial begin
    w = $urandom(67);
    tick(3);
    i_rst_b = 1;
    chk("ext0 flag", o_ext0_pending, 1);
    chk("ext1 flag", o_ext1_pending, 1);
    clr;
    chk("ext flags", {o_ext1_pending, o_ext0_pending}, 0);
    $display("reset test done");
    i_irq_enable_reg = 8'h1F;
    i_timer0_overflow = 1;
    tick(1);
    i_timer0_overflow = 0;
    tick(20);
    chk("flags", {o_serial_rx_pending, o_timer1_overflow_pending, o_timer0_overflow_pending}, 7);
    chk("vector", o_vector, 16'h0000);
    i_ext0_polarity_select = 1;
    clr;
    i_pin_p00 = 1;
    i_pin_p02 = 0;
    tick(3);
    chk("ext0 flag", o_ext0_pending, 1);
    i_ext0_trigger_select = 0;
    clr;
    chk("ext0 level", o_ext0_pending, 1);
    i_ext0_trigger_select = 1;
    clr;
    chk("ext0 edge", o_ext0_pending, 0);
    i_serial_set_wr = 2'h2;
    tick(1);
    i_serial_set_wr = 2'h0;
    chk("tx flag", o_serial_tx_pending, 1);
    i_ext1_source_select = 1;
    clr;
    repeat (2) begin
      i_lf_osc_tick = 1;
      tick(1);
      i_lf_osc_tick = 0;
      tick(2);
    end
    chk("ext1 flag", o_ext1_pending, 1);
    i_ext1_source_select = 0;
    clr;
    i_osc_resume = 1;
    tick(1);
    i_osc_resume = 0;
    tick(1);
    chk("ext1 resume", o_ext1_pending, 1);
    $display("source test done");
    i_ext1_source_select = 0;
    for (i = 0; i < 12; i = i + 1) begin
      clr;
      m = 7'($urandom % 127 + 1);
      i_irq_level_reg = 8'($urandom) & 8'h1F;
      i_ext_level_reg_one = 8'($urandom) & 8'h02;
      i_ext_level_reg_two = 8'($urandom) & 8'h01;
      i_flag_set_wr = m[3:0];
      i_serial_set_wr = {1'b0, m[4]};
      tick(1);
      i_flag_set_wr = 4'h0;
      i_serial_set_wr = 2'h0;
      {i_bus_voltage_request, i_usb_request} = m[6:5];
      {i_irq_enable_reg, i_ext_enable_reg_one, i_ext_enable_reg_two} = {8'h9F, 8'h02, 8'h01};
      lv = {i_ext_level_reg_two[0], i_ext_level_reg_one[1], i_irq_level_reg[4:0]};
      x = win(m, lv);
      for (k = 0; k < 4; k = k + 1) wb[k] = (VT[k*16 +: 16] == x);
      for (w = 0; o_long_call !== 1'b1 && w < 200; w = w + 1) tick(1);
      if (w == 200) begin
        n_fail = n_fail + 1;
        conclude;
      end
      chk("vector", o_vector, x);
      chk("busy", o_call_busy, 0);
      chk("service", o_in_service, (win(m & lv, lv) == 16'hFFFF) ? 2'b01 : 2'b10);
      chk("flags", {o_serial_rx_pending, o_timer1_overflow_pending, o_ext1_pending,
        o_timer0_overflow_pending, o_ext0_pending}, {m[4], m[3:0] & ~wb});
      i_irq_enable_reg = 8'h00;
      {i_bus_voltage_request, i_usb_request} = 2'b00;
      tick(24);
      chk("service end", o_in_service, 0);
    end
    $display("arbitration test done");
    conclude;
  end
endmodule // mcuih_top_bench
